// *** common/ulf_regs.vh ***
// register offsets, field positions, reset values and format constants for the line format block
// assumes a plain address/strobe register port with one-cycle read latency
`ifndef ULF_REGS_VH
`define ULF_REGS_VH

// ============================================================
// register offsets
`define ULF_ADDR_W          4
`define ULF_OFS_ISTAT       4'h2
`define ULF_OFS_LFC         4'h3
`define ULF_OFS_MLC         4'h4
`define ULF_OFS_DIVLO       4'h0
`define ULF_OFS_DIVHI       4'h1
`define ULF_OFS_EVSTAT      4'h8
`define ULF_OFS_EVMASK      4'h9
`define ULF_OFS_TXDATA      4'hA

// ============================================================
// line_format_control fields
`define ULF_LFC_DLAB        7
`define ULF_LFC_BREAK       6
`define ULF_LFC_PAR_HI      5
`define ULF_LFC_PAR_LO      3
`define ULF_LFC_STOP        2
`define ULF_LFC_WLEN_HI     1
`define ULF_LFC_WLEN_LO     0
`define ULF_LFC_RESET       8'h00

// ============================================================
// modem_line_control and status fields
`define ULF_MLC_PRESC       7
`define ULF_MLC_RESET       8'h00
`define ULF_ISTAT_NOPEND    0
`define ULF_ISTAT_RESET     8'h01
`define ULF_DIV_RESET       16'h0001

// ============================================================
// events: bit 0 character sent, bit 1 break started
`define ULF_EV_TXDONE       0
`define ULF_EV_BREAK        1
`define ULF_EV_W            2

// ============================================================
// timing: half-bit ticks per bit, prescale ratio
`define ULF_HALF_PER_BIT    2
`define ULF_PRESC_DIV       4
`endif

// *** dv/tb_uart_line_format_control.sv ***
// bench for the line format block: register tasks, frames, events, break
// assumes divisor stays one, so a bit lasts two clocks undivided
`timescale 1ns/1ns
`default_nettype none
`include "ulf_regs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
// ================================
// bench
module tb_uart_line_format_control;
    logic       i_mclk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 0, o_data_bits, n, nb;
    logic [7:0] i_wdata = 0, o_rdata, bc, d, dm, lf, ml;
    logic [8:0] rx_word, ew;
    logic       o_irq, o_txd, o_tx_busy, o_parity_en, rx_stop, p, par;
    int         miscompares = 0, n_compared = 0, cyc = 0, cnt, eb;
    logic [7:0] f_lfc [7] = '{8'h00, 8'h0D, 8'h1B, 8'h2A, 8'h3F, 8'h04, 8'h03};
    logic [7:0] f_dat [7] = '{8'h15, 8'h2C, 8'hC3, 8'h5A, 8'h81, 8'h0A, 8'hA5};
    ulf_line_format i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_txd(o_txd),
        .o_tx_busy(o_tx_busy), .o_data_bits(o_data_bits), .o_parity_en(o_parity_en));
    ulf_rx_model i_rx (.i_mclk(i_mclk), .i_txd(o_txd), .i_bit_cyc(bc), .i_nbits(nb),
        .o_word(rx_word), .o_stop(rx_stop));
    // clock and hang guard
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        `CHK(o_rdata, e)
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // reset values, latch access, frames, interrupt, break
    initial begin
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        chk(`ULF_OFS_ISTAT, 8'h01);
        chk(`ULF_OFS_LFC, 8'h00);
        chk(`ULF_OFS_MLC, 8'h00);
        chk(4'h5, 8'h00);
        chk(`ULF_OFS_DIVLO, 8'h00);
        wr(`ULF_OFS_LFC, 8'h80);
        wr(`ULF_OFS_TXDATA, 8'h55);
        @(negedge i_mclk);
        `CHK(o_tx_busy, 1'b0)
        chk(`ULF_OFS_DIVLO, 8'h01);
        wr(`ULF_OFS_DIVLO, 8'h01);
        wr(`ULF_OFS_LFC, 8'h00);
        for (int k = 0; k < 7; k++) begin
            lf = f_lfc[k];
            ml = (k == 6) ? 8'h80 : 8'h00;
            n = 4'h5 + {2'b00, lf[1:0]};
            p = lf[3];
            dm = f_dat[k] & (8'hFF >> (8 - n));
            par = (lf[5:4] == 2'b00) ? ~^dm : (lf[5:4] == 2'b01) ? ^dm : ~lf[4];
            ew = {1'b0, dm} | (p ? {8'h00, par} << n : 9'h000);
            bc = ml[7] ? 8'h08 : 8'h02;
            nb = n + {3'b000, p};
            eb = (2 * (1 + nb) + (lf[2] ? ((n == 5) ? 3 : 4) : 2)) * (bc / 2);
            wr(`ULF_OFS_LFC, lf);
            wr(`ULF_OFS_MLC, ml);
            chk(`ULF_OFS_MLC, ml);
            wr(`ULF_OFS_TXDATA, f_dat[k]);
            cnt = 0;
            @(negedge i_mclk);
            while (o_tx_busy === 1'b1 && cnt < 2000) begin
                cnt++;
                @(negedge i_mclk);
            end
            `CHK(cnt, eb)
            `CHK(rx_word, ew)
            `CHK(rx_stop, 1'b1)
            `CHK(o_data_bits, n)
            `CHK(o_parity_en, p)
        end
        chk(`ULF_OFS_EVSTAT, 8'h01);
        `CHK(o_irq, 1'b0)
        wr(`ULF_OFS_EVMASK, 8'h01);
        @(negedge i_mclk);
        `CHK(o_irq, 1'b1)
        chk(`ULF_OFS_ISTAT, 8'h00);
        wr(`ULF_OFS_EVSTAT, 8'h01);
        @(negedge i_mclk);
        `CHK(o_irq, 1'b0)
        chk(`ULF_OFS_ISTAT, 8'h01);
        wr(`ULF_OFS_LFC, 8'h40);
        repeat (6) @(negedge i_mclk);
        `CHK(o_txd, 1'b0)
        chk(`ULF_OFS_EVSTAT, 8'h02);
        wr(`ULF_OFS_EVMASK, 8'h00);
        wr(`ULF_OFS_LFC, 8'h00);
        @(negedge i_mclk);
        `CHK(o_txd, 1'b1)
        finish_test();
    end
endmodule // tb_uart_line_format_control
`default_nettype wire

// *** dv/ulf_line_format_checker.sv ***
// assertions on the ports of the line format block
// assumes one clock, divisor left at one by the bench
`timescale 1ns/1ns
`default_nettype none
`include "ulf_regs.vh"
// ================================
// checker
module ulf_lf_checker (
    input wire logic                   i_mclk,
    input wire logic                   i_reset,
    input wire logic [`ULF_ADDR_W-1:0] i_addr,
    input wire logic [7:0]             i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [7:0]             o_rdata,
    input wire logic                   o_irq,
    input wire logic                   o_txd,
    input wire logic                   o_tx_busy,
    input wire logic [3:0]             o_data_bits,
    input wire logic                   o_parity_en
);
    logic [7:0] lfc_r;
    logic       mlc_r;
    wire        go = i_wr && i_addr == `ULF_OFS_TXDATA && !lfc_r[7] && !o_tx_busy;
    // shadow of format and prescale bits
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            lfc_r <= `ULF_LFC_RESET;
            mlc_r <= 1'b0;
        end else if (i_wr && i_addr == `ULF_OFS_LFC) begin
            lfc_r <= i_wdata;
        end else if (i_wr && i_addr == `ULF_OFS_MLC) begin
            mlc_r <= i_wdata[7];
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence start_s; go && mlc_r; endsequence
    sequence slow_s; (!o_txd) [*8]; endsequence
    istat_bit_a: assert property (i_rd && i_addr == `ULF_OFS_ISTAT |=> o_rdata == {7'h00, !$past(o_irq)})
        else $error("status bit zero wrong");
    mask_off_a: assert property (i_wr && i_addr == `ULF_OFS_EVMASK && i_wdata == 8'h00 |=> !o_irq)
        else $error("irq with mask clear");
    latch_hide_a: assert property (i_rd && i_addr <= `ULF_OFS_DIVHI && !lfc_r[7] |=> o_rdata == 8'h00)
        else $error("divisor visible");
    tx_refuse_a: assert property (i_wr && i_addr == `ULF_OFS_TXDATA && lfc_r[7] && !o_tx_busy |=> !o_tx_busy)
        else $error("tx taken with latch open");
    break_low_a: assert property (lfc_r[6] |-> !o_txd)
        else $error("break not low");
    parity_en_a: assert property (o_parity_en == lfc_r[3])
        else $error("parity enable wrong");
    stop_high_a: assert property ($fell(o_tx_busy) && !lfc_r[6] |-> $past(o_txd))
        else $error("stop bit low");
    word_len_a: assert property (o_data_bits == 4'h5 + {2'b00, lfc_r[1:0]})
        else $error("word length wrong");
    start_fast_a: assert property (go && !mlc_r |=> o_tx_busy && !o_txd ##1 !o_txd)
        else $error("start bit wrong");
    start_slow_a: assert property (start_s |=> slow_s)
        else $error("prescale wrong");
endmodule // ulf_lf_checker
bind ulf_line_format ulf_lf_checker i_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_txd(o_txd),
    .o_tx_busy(o_tx_busy), .o_data_bits(o_data_bits), .o_parity_en(o_parity_en));
`default_nettype wire

// *** dv/ulf_rx_model.sv ***
// remote serial station: decodes frames seen on the transmit line
// assumes the bench sets the bit time in clocks and the count of data plus parity bits per frame
`timescale 1ns/1ns
`default_nettype none
// ================================
// receiver model
module ulf_rx_model (
    input  wire logic       i_mclk,
    input  wire logic       i_txd,
    input  wire logic [7:0] i_bit_cyc,
    input  wire logic [3:0] i_nbits,
    output var  logic [8:0] o_word,
    output var  logic       o_stop
);
    // start edge, then mid-bit samples lsb first, then the stop bit
    always begin
        @(negedge i_txd);
        repeat (i_bit_cyc / 2) @(negedge i_mclk);
        o_word = 9'h000;
        for (int k = 0; k < i_nbits; k++) begin
            repeat (i_bit_cyc) @(negedge i_mclk);
            o_word[k] = i_txd;
        end
        repeat (i_bit_cyc) @(negedge i_mclk);
        o_stop = i_txd;
    end
endmodule // ulf_rx_model
`default_nettype wire

// *** verilog/ulf_line_format.v ***
// line format control, break, parity, stop bits, prescaler select and interrupt status
// assumes a synchronous register port: write strobe, read strobe, read data one cycle later
// Contract
// - status bit zero low while interrupt pending
// - top format bit maps divisor latch registers
// - break bit holds transmit line low
// - bits five-three select parity mode
// - stop bit count from bit two
// - low two bits select word length
// - modem control top bit divides clock four
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ulf_regs.vh"

module ulf_line_format (
    input  wire                   i_mclk,
    input  wire                   i_reset,
    input  wire [`ULF_ADDR_W-1:0] i_addr,
    input  wire [7:0]             i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output reg  [7:0]             o_rdata,
    output wire                   o_irq,
    output wire                   o_txd,
    output wire                   o_tx_busy,
    output wire [3:0]             o_data_bits,
    output wire                   o_parity_en
);
    // ============================================================
    // registers
    reg  [7:0]  lfc_r;
    reg  [7:0]  mlc_r;
    reg  [15:0] div_r;
    reg  [`ULF_EV_W-1:0] ev_r;
    reg  [`ULF_EV_W-1:0] ev_nxt;
    reg  [`ULF_EV_W-1:0] mask_r;
    reg  [7:0]  rdata_nxt;
    wire        dlab;
    wire        half_tick;
    wire        pending;
    wire [7:0]  istat;

    // ============================================================
    // helper functions
    // word length code to data bit count
    function [3:0] wlen_bits;
        input [1:0] code;
        begin
            wlen_bits = 4'h5 + {2'b00, code};
        end
    endfunction

    // parity bit value for a data byte and mode code
    function par_bit;
        input [7:0] data;
        input [3:0] nbits;
        input [2:0] mode;
        reg   [7:0] m;
        begin
            m = data & ~(8'hFF << nbits);
            case (mode)
                3'b001:  par_bit = ~(^m);   // odd
                3'b011:  par_bit = ^m;      // even
                3'b101:  par_bit = 1'b1;    // forced one
                3'b111:  par_bit = 1'b0;    // forced zero
                default: par_bit = ~(^m);   // 3'b??0 codes, parity off, give the odd value
            endcase
        end
    endfunction

    assign dlab        = lfc_r[`ULF_LFC_DLAB];
    assign o_data_bits = wlen_bits(lfc_r[`ULF_LFC_WLEN_HI:`ULF_LFC_WLEN_LO]);
    assign o_parity_en = lfc_r[`ULF_LFC_PAR_LO];

    // ============================================================
    // baud tick source
    ulf_prescaler u_presc (
        .i_mclk      (i_mclk),
        .i_reset     (i_reset),
        .i_div4      (mlc_r[`ULF_MLC_PRESC]),
        .i_run       (o_tx_busy),
        .i_divisor   (div_r),
        .o_half_tick (half_tick)
    );

    // ============================================================
    // transmitter: counts half-bit ticks; states idle, start, data, parity, stop
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_STRT = 3'd1;
    localparam [2:0] ST_DATA = 3'd2;
    localparam [2:0] ST_PAR  = 3'd3;
    localparam [2:0] ST_STOP = 3'd4;

    reg  [2:0] st_r;
    reg  [7:0] sh_r;
    reg  [3:0] bit_r;
    reg  [2:0] half_r;
    reg        line_r;
    reg        parv_r;
    reg        done_p;
    wire [2:0] stop_halves;
    wire       tx_wr;

    // stop length in half bits: 2, 3 for five-bit words, else 4
    assign stop_halves = !lfc_r[`ULF_LFC_STOP] ? 3'd2 :
                         (lfc_r[1:0] == 2'b00) ? 3'd3 : 3'd4;
    assign tx_wr     = i_wr && !dlab && (i_addr == `ULF_OFS_TXDATA);
    assign o_tx_busy = (st_r != ST_IDLE);
    assign o_txd     = line_r & ~lfc_r[`ULF_LFC_BREAK];

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st_r   <= ST_IDLE;
            sh_r   <= 8'h00;
            bit_r  <= 4'h0;
            half_r <= 3'd0;
            line_r <= 1'b1;
            parv_r <= 1'b0;
            done_p <= 1'b0;
        end else begin
            done_p <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    line_r <= 1'b1;
                    if (tx_wr) begin
                        sh_r   <= i_wdata;
                        parv_r <= par_bit(i_wdata, o_data_bits, lfc_r[5:3]);
                        st_r   <= ST_STRT;
                        half_r <= 3'd0;
                        line_r <= 1'b0;
                    end
                end
                ST_STRT, ST_DATA, ST_PAR: begin
                    if (half_tick) begin
                        if (half_r == 3'd1) begin
                            half_r <= 3'd0;
                            if (st_r == ST_STRT) begin
                                st_r   <= ST_DATA;
                                bit_r  <= 4'h0;
                                line_r <= sh_r[0];
                            end else if (st_r == ST_DATA && bit_r + 4'h1 < o_data_bits) begin
                                bit_r  <= bit_r + 4'h1;
                                sh_r   <= {1'b0, sh_r[7:1]};
                                line_r <= sh_r[1];
                            end else if (st_r == ST_DATA && o_parity_en) begin
                                st_r   <= ST_PAR;
                                line_r <= parv_r;
                            end else begin
                                st_r   <= ST_STOP;
                                line_r <= 1'b1;
                            end
                        end else begin
                            half_r <= half_r + 3'd1;
                        end
                    end
                end
                ST_STOP: begin
                    if (half_tick) begin
                        if (half_r + 3'd1 >= stop_halves) begin
                            st_r   <= ST_IDLE;
                            half_r <= 3'd0;
                            done_p <= 1'b1;
                        end else begin
                            half_r <= half_r + 3'd1;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // break edge detect for the event register
    reg brk_d_r;
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset)
            brk_d_r <= 1'b0;
        else
            brk_d_r <= lfc_r[`ULF_LFC_BREAK];
    end

    // ============================================================
    // sticky events: set wins over write-one-to-clear
    always @* begin
        ev_nxt = ev_r;
        if (i_wr && i_addr == `ULF_OFS_EVSTAT)
            ev_nxt = ev_nxt & ~i_wdata[`ULF_EV_W-1:0];
        if (done_p)
            ev_nxt[`ULF_EV_TXDONE] = 1'b1;
        if (lfc_r[`ULF_LFC_BREAK] && !brk_d_r)
            ev_nxt[`ULF_EV_BREAK] = 1'b1;
    end

    assign pending = |(ev_r & mask_r);
    assign o_irq   = pending;
    // pending flag active low in bit zero
    assign istat   = {7'h00, ~pending};

    // ============================================================
    // register writes; divisor reachable only with latch bit set
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            lfc_r  <= `ULF_LFC_RESET;
            mlc_r  <= `ULF_MLC_RESET;
            div_r  <= `ULF_DIV_RESET;
            ev_r   <= {`ULF_EV_W{1'b0}};
            mask_r <= {`ULF_EV_W{1'b0}};
        end else begin
            ev_r <= ev_nxt;
            if (i_wr) begin
                case (i_addr)
                    `ULF_OFS_LFC:    lfc_r  <= i_wdata;
                    `ULF_OFS_MLC:    mlc_r  <= i_wdata;
                    `ULF_OFS_DIVLO:  if (dlab) div_r[7:0]  <= i_wdata;
                    `ULF_OFS_DIVHI:  if (dlab) div_r[15:8] <= i_wdata;
                    `ULF_OFS_EVMASK: mask_r <= i_wdata[`ULF_EV_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ============================================================
    // read mux; unmapped reads return zero
    always @* begin
        rdata_nxt = 8'h00;
        case (i_addr)
            `ULF_OFS_ISTAT:  rdata_nxt = istat;
            `ULF_OFS_LFC:    rdata_nxt = lfc_r;
            `ULF_OFS_MLC:    rdata_nxt = mlc_r;
            `ULF_OFS_DIVLO:  rdata_nxt = dlab ? div_r[7:0]  : 8'h00;
            `ULF_OFS_DIVHI:  rdata_nxt = dlab ? div_r[15:8] : 8'h00;
            `ULF_OFS_EVSTAT: rdata_nxt = {6'h00, ev_r};
            `ULF_OFS_EVMASK: rdata_nxt = {6'h00, mask_r};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    // read data valid the cycle after the strobe only
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rdata_nxt;
        else
            o_rdata <= 8'h00;
    end
endmodule // ulf_line_format
`default_nettype wire

// *** verilog/ulf_prescaler.v ***
// clock prescaler and baud tick generator for the line format block
// assumes one clock domain; produces a one-cycle half-bit tick enable
`timescale 1ns/1ns
`default_nettype none
`include "ulf_regs.vh"

module ulf_prescaler (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_div4,
    input  wire        i_run,
    input  wire [15:0] i_divisor,
    output wire        o_half_tick
);
    // ============================================================
    // prescale stage
    reg  [1:0]  pre_r;
    reg  [15:0] cnt_r;
    wire        pre_en;

    // by-one or by-four enable to the baud counter
    assign pre_en = i_div4 ? (pre_r == 2'h3) : 1'b1;

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pre_r <= 2'h0;
            cnt_r <= 16'h0000;
        end else if (!i_run) begin
            // held at phase zero while idle so every frame starts with full bit times
            pre_r <= 2'h0;
            cnt_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 2'h1;
            if (pre_en) begin
                if (cnt_r >= i_divisor - 16'h0001)
                    cnt_r <= 16'h0000;
                else
                    cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // one tick per divisor period of prescaled clock
    assign o_half_tick = i_run && pre_en && (cnt_r >= i_divisor - 16'h0001);
endmodule // ulf_prescaler
`default_nettype wire
